// file: ssp_peer.sv
// Shift-register peer on the far side of the serial link
`timescale 1ns/1ps
module ssp_peer (
    // Link
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    // Bench control
    input  wire logic       pol,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic [7:0]      sr
);
    logic bit_r;
    // Latch on the first edge, shift on the trailing edge
    always @(posedge load or posedge sclk or negedge sclk) begin
        if (load)
            sr <= load_val;
        else if (sclk != pol)
            bit_r <= mosi;
        else
            sr <= {sr[6:0], bit_r};
    end
    // Top bit always on the return line
    assign miso = sr[7];
endmodule : ssp_peer

// file: ssp_pkg.sv
// Package for the synchronous serial port: register map, fields, reset values
package ssp_pkg;
    // APB byte offsets
    localparam logic [7:0] ADDR_CONFIG  = 8'h00;  // serial_config_reg
    localparam logic [7:0] ADDR_OPCTL   = 8'h04;  // serial_operation_ctl_reg
    localparam logic [7:0] ADDR_RXBUF   = 8'h08;  // receive_buffer_reg
    localparam logic [7:0] ADDR_SHIFT   = 8'h0C;  // shift_data_reg
    localparam logic [7:0] ADDR_PRIO    = 8'h10;  // serial_priority_reg
    // Configuration fields
    localparam int CFG_LEN_LSB   = 0;
    localparam int CFG_RATE_LSB  = 3;
    localparam int CFG_POL_BIT   = 6;
    localparam int CFG_SRST_BIT  = 7;
    // Operation control fields
    localparam int CTL_IEN_BIT   = 0;
    localparam int CTL_TRANSMIT_PERMIT_BIT_BIT  = 1;
    localparam int CTL_MSTR_BIT  = 2;
    localparam int CTL_DONE_BIT  = 6;
    localparam int CTL_OVR_BIT   = 7;
    // Priority field
    localparam int PRI_LEVEL_BIT = 6;
    // Reset values
    localparam logic [7:0] CONFIG_RST = 8'h80;  // Port held in soft reset
    localparam logic [7:0] OPCTL_RST  = 8'h00;
    localparam logic [7:0] PRIO_RST   = 8'h00;
    // Slave clock synchroniser depth
    localparam int SYNC_STAGES = 2;
    // Transfer states
    typedef enum logic [2:0] {
        SSP_IDLE  = 3'b001,
        SSP_LEAD  = 3'b010,
        SSP_TRAIL = 3'b100
    } ssp_state_t;
endpackage : ssp_pkg

// file: ssp_port.sv
// Synchronous serial master/slave shift port with APB register access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - Master write to shift register starts transfer
// - Shift register contents change after every transfer
// - Slave shifts on external clock edges
// - Transmit-permit clear stops data driving
// - Reception continues with transmit-permit clear
// - Soft reset freezes port during configuration
// - Length code plus one gives bits
// - Transmit MSB first, left justified
// - Receive into LSB, right justified
// - Master clock is system/(2*2^rate)
// - Rate field ignored in slave mode
// - Polarity bit selects latching edge
// - Interrupt on completion when enabled
// - Completion flag set every character
// - Flag cleared by buffer read, resets
// - Request stays while flag and enable
// - Overrun flag reports lost data
// - Completed character latched into buffer
module ssp_port
    import ssp_pkg::*;
(
    // System
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Serial clock pin
    input  wire logic        SCLK_I,
    output logic             SCLK_O,
    output logic             SCLK_OE_N,
    // Data pins, role swapped by mode
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE_N,
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE_N,
    // Interrupt request and level
    output logic             IRQ,
    output logic             IRQ_PRIO
);
    import ssp_pkg::*;

    // Registers and next values
    logic [7:0]  cfg_r, cfg_nxt;
    logic [7:0]  ctl_r, ctl_nxt;      // bits 6,7 unused here; flags live below
    logic [7:0]  pri_r, pri_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic [7:0]  rxbuf_r, rxbuf_nxt;
    logic        done_r, done_nxt;
    logic        ovr_r, ovr_nxt;
    logic [3:0]  bits_r, bits_nxt;
    logic [7:0]  div_r, div_nxt;
    logic        sclk_r, sclk_nxt;
    logic        out_r, out_nxt;
    ssp_state_t  st_r, st_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [SYNC_STAGES-1:0] sync_r;
    logic        sclk_q_r;

    // Decoded views
    logic        srst, master, transmit_permit_bit, pol;
    logic [3:0]  char_len;
    logic [7:0]  half_period;
    logic        acc, wr, rd;
    logic        rx_bit, lead_edge, trail_edge;

    // Half period in system clocks: 2^rate
    function automatic logic [7:0] half_div(input logic [2:0] rate);
        half_div = 8'h01 << rate;
    endfunction : half_div

    assign srst        = cfg_r[CFG_SRST_BIT];
    assign master      = ctl_r[CTL_MSTR_BIT];
    assign transmit_permit_bit        = ctl_r[CTL_TRANSMIT_PERMIT_BIT_BIT];
    assign pol         = cfg_r[CFG_POL_BIT];
    assign char_len    = {1'b0, cfg_r[CFG_LEN_LSB +: 3]} + 4'h1;
    assign half_period = half_div(cfg_r[CFG_RATE_LSB +: 3]);
    assign acc         = PSEL && PENABLE && !pready_r;
    assign wr          = acc && PWRITE;
    assign rd          = acc && !PWRITE;
    // Master samples the in line, slave the out line
    assign rx_bit      = master ? MISO_I : MOSI_I;

    // Slave clock edges; first stage read only by second stage
    assign lead_edge  = !master && (sync_r[SYNC_STAGES-1] != sclk_q_r)
                        && (sync_r[SYNC_STAGES-1] == !pol);
    assign trail_edge = !master && (sync_r[SYNC_STAGES-1] != sclk_q_r)
                        && (sync_r[SYNC_STAGES-1] == pol);

    // Register, transfer and bus next-state logic
    always_comb begin
        logic done_evt;
        logic [7:0] sh_in;
        done_evt    = 1'b0;
        sh_in       = {shift_r[6:0], rx_bit};
        cfg_nxt     = cfg_r;
        ctl_nxt     = ctl_r;
        pri_nxt     = pri_r;
        shift_nxt   = shift_r;
        rxbuf_nxt   = rxbuf_r;
        done_nxt    = done_r;
        ovr_nxt     = ovr_r;
        bits_nxt    = bits_r;
        div_nxt     = div_r;
        sclk_nxt    = sclk_r;
        out_nxt     = out_r;
        st_nxt      = st_r;
        prdata_nxt  = 32'h0000_0000;
        pready_nxt  = acc;
        pslverr_nxt = 1'b0;

        // Shift engine, frozen under soft reset
        if (srst) begin
            st_nxt   = SSP_IDLE;
            sclk_nxt = pol;
            bits_nxt = 4'h0;
            div_nxt  = 8'h00;
        end else if (master) begin
            unique case (st_r)
                SSP_IDLE: begin
                    sclk_nxt = pol;
                    out_nxt  = shift_r[7];
                end
                SSP_LEAD: begin
                    if (div_r == 8'h01) begin
                        div_nxt   = half_period;
                        sclk_nxt  = !pol;
                        shift_nxt = sh_in;
                        st_nxt    = SSP_TRAIL;
                    end else begin
                        div_nxt = div_r - 8'h01;
                    end
                end
                SSP_TRAIL: begin
                    if (div_r == 8'h01) begin
                        div_nxt  = half_period;
                        sclk_nxt = pol;
                        out_nxt  = shift_r[7];
                        if (bits_r == char_len - 4'h1) begin
                            done_evt = 1'b1;
                            st_nxt   = SSP_IDLE;
                        end else begin
                            bits_nxt = bits_r + 4'h1;
                            st_nxt   = SSP_LEAD;
                        end
                    end else begin
                        div_nxt = div_r - 8'h01;
                    end
                end
                default: st_nxt = SSP_IDLE;
            endcase
        end else begin
            sclk_nxt = pol;
            if (lead_edge) begin
                shift_nxt = sh_in;
                if (bits_r == char_len - 4'h1) begin
                    done_evt = 1'b1;
                    bits_nxt = 4'h0;
                end else begin
                    bits_nxt = bits_r + 4'h1;
                end
            end
            if (trail_edge) begin
                out_nxt = shift_r[7];
            end
        end

        // Completion: latch buffer, set flags; set wins over clear
        if (rd && PADDR == ADDR_RXBUF) begin
            done_nxt = 1'b0;
        end
        if (done_evt) begin
            rxbuf_nxt = shift_nxt;
            done_nxt  = 1'b1;
            ovr_nxt   = ovr_r || done_r;
        end
        if (srst) begin
            done_nxt = 1'b0;
            ovr_nxt  = 1'b0;
        end

        // APB access
        if (wr) begin
            unique case (PADDR)
                ADDR_CONFIG: cfg_nxt = PWDATA[7:0];
                ADDR_OPCTL:  ctl_nxt = {2'b00, 3'b000, PWDATA[2:0]};
                ADDR_PRIO:   pri_nxt = {1'b0, PWDATA[PRI_LEVEL_BIT], 6'h00};
                ADDR_SHIFT: begin
                    if (!srst) begin
                        shift_nxt = PWDATA[7:0];
                        out_nxt   = PWDATA[7];
                        if (master) begin
                            st_nxt   = SSP_LEAD;
                            div_nxt  = half_period;
                            bits_nxt = 4'h0;
                        end
                    end
                end
                ADDR_RXBUF: ;
                default: pslverr_nxt = 1'b1;
            endcase
        end else if (rd) begin
            unique case (PADDR)
                ADDR_CONFIG: prdata_nxt = {24'h000000, cfg_r};
                ADDR_OPCTL:  prdata_nxt = {24'h000000, ovr_r, done_r, 3'b000, ctl_r[2:0]};
                ADDR_RXBUF:  prdata_nxt = {24'h000000, rxbuf_r};
                ADDR_SHIFT:  prdata_nxt = {24'h000000, shift_r};
                ADDR_PRIO:   prdata_nxt = {24'h000000, pri_r};
                default:     pslverr_nxt = 1'b1;
            endcase
        end
        if (!master && st_r != SSP_IDLE) begin
            st_nxt = SSP_IDLE;
        end
    end

    // State registers
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            cfg_r     <= CONFIG_RST;
            ctl_r     <= OPCTL_RST;
            pri_r     <= PRIO_RST;
            shift_r   <= 8'h00;
            rxbuf_r   <= 8'h00;
            done_r    <= 1'b0;
            ovr_r     <= 1'b0;
            bits_r    <= 4'h0;
            div_r     <= 8'h00;
            sclk_r    <= 1'b0;
            out_r     <= 1'b0;
            st_r      <= SSP_IDLE;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            sync_r    <= '0;
            sclk_q_r  <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            ctl_r     <= ctl_nxt;
            pri_r     <= pri_nxt;
            shift_r   <= shift_nxt;
            rxbuf_r   <= rxbuf_nxt;
            done_r    <= done_nxt;
            ovr_r     <= ovr_nxt;
            bits_r    <= bits_nxt;
            div_r     <= div_nxt;
            sclk_r    <= sclk_nxt;
            out_r     <= out_nxt;
            st_r      <= st_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            sync_r    <= {sync_r[SYNC_STAGES-2:0], SCLK_I};
            sclk_q_r  <= sync_r[SYNC_STAGES-1];
        end
    end

    // Pin and interrupt output registers
    logic sclk_oe_n_r, mosi_oe_n_r, miso_oe_n_r, irq_r, prio_r;
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            sclk_oe_n_r <= 1'b1;
            mosi_oe_n_r <= 1'b1;
            miso_oe_n_r <= 1'b1;
            irq_r       <= 1'b0;
            prio_r      <= 1'b0;
        end else begin
            sclk_oe_n_r <= !master;
            mosi_oe_n_r <= !(master && transmit_permit_bit);
            miso_oe_n_r <= !(!master && transmit_permit_bit);
            irq_r       <= done_nxt && ctl_nxt[CTL_IEN_BIT];
            prio_r      <= pri_nxt[PRI_LEVEL_BIT];
        end
    end

    assign PRDATA    = prdata_r;
    assign PREADY    = pready_r;
    assign PSLVERR   = pslverr_r;
    assign SCLK_O    = sclk_r;
    assign SCLK_OE_N = sclk_oe_n_r;
    assign MOSI_O    = out_r;
    assign MOSI_OE_N = mosi_oe_n_r;
    assign MISO_O    = out_r;
    assign MISO_OE_N = miso_oe_n_r;
    assign IRQ       = irq_r;
    assign IRQ_PRIO  = prio_r;
endmodule : ssp_port

// file: ssp_port_monitor.sv
// Concurrent checks on the serial port's bus and pin behaviour
`timescale 1ns/1ps
module ssp_port_monitor
    import ssp_pkg::*;
(
    // System
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Pins
    input wire logic        SCLK_OE_N,
    input wire logic        MOSI_OE_N,
    input wire logic        MISO_OE_N,
    input wire logic        IRQ,
    input wire logic        IRQ_PRIO
);
    logic mapped;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // Offsets that answer without error
    assign mapped = PADDR inside {ADDR_CONFIG, ADDR_OPCTL, ADDR_RXBUF, ADDR_SHIFT, ADDR_PRIO};
    // Bus answer shape
    rdy_pulse_a: assert property (PREADY |=> !PREADY)  // one-cycle answer
        else $error("ready held longer than one cycle");
    rdy_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)  // fixed latency
        else $error("ready missing after access phase");
    err_map_a: assert property (PREADY |-> PSLVERR == !mapped)  // unmapped offsets
        else $error("error flag does not match address map");
    rdata_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)  // byte registers
        else $error("upper read data not zero");
    // Interrupt level and priority copy
    irq_hold_a: assert property (IRQ && !PSEL && !$past(PSEL) && !$past(PSEL, 2) |=> IRQ)
        else $error("interrupt dropped without bus access");
    prio_copy_a: assert property (PREADY && PWRITE && PADDR == ADDR_PRIO |=> ##1
        IRQ_PRIO == $past(PWDATA[6], 2))
        else $error("priority output does not follow write");
    // Pin direction follows mode
    oe_excl_a: assert property (!(!MOSI_OE_N && !MISO_OE_N))
        else $error("both data outputs enabled");
    slave_clk_a: assert property (!MISO_OE_N |-> SCLK_OE_N)
        else $error("clock driven while slave");
    master_clk_a: assert property (!MOSI_OE_N |-> !SCLK_OE_N)
        else $error("clock not driven while master talks");
endmodule : ssp_port_monitor

bind ssp_port ssp_port_monitor ssp_port_monitor_i (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCLK_OE_N(SCLK_OE_N),
    .MOSI_OE_N(MOSI_OE_N), .MISO_OE_N(MISO_OE_N), .IRQ(IRQ), .IRQ_PRIO(IRQ_PRIO));

// file: ssp_port_tb.sv
// Self-checking bench for the serial port in master and slave mode
`timescale 1ns/1ps
module ssp_port_tb;
    import ssp_pkg::*;
    logic        CLK_SYS = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h0;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic        PREADY, PSLVERR, SCLK_O, SCLK_OE_N, MOSI_O, MOSI_OE_N, MISO_OE_N, IRQ, IRQ_PRIO;
    logic        load = 1'b0, pol = 1'b0, miso, sclk_w, mosi_w, peer_in, MISO_O;
    logic        slv = 1'b0, ext_act = 1'b0;  // Port is link master, bench clock at rest
    logic [7:0]  load_val = 8'h0, peer_sr;
    int          n_mismatch = 0, comparisons = 0, cycles = 0;
    // Released clock rests at idle level unless the bench clocks it; data lines pulled up
    assign sclk_w  = SCLK_OE_N ? (pol ^ ext_act) : SCLK_O;
    // Slave runs swap the lines: peer drives the port's MOSI and samples its MISO
    assign mosi_w  = slv ? miso : (MOSI_OE_N ? 1'b1 : MOSI_O);
    assign peer_in = slv ? (MISO_OE_N ? 1'b1 : MISO_O) : mosi_w;
    ssp_port ssp_port_i (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SCLK_I(sclk_w), .SCLK_O(SCLK_O), .SCLK_OE_N(SCLK_OE_N),
        .MOSI_I(mosi_w), .MOSI_O(MOSI_O), .MOSI_OE_N(MOSI_OE_N), .MISO_I(miso), .MISO_O(MISO_O),
        .MISO_OE_N(MISO_OE_N), .IRQ(IRQ), .IRQ_PRIO(IRQ_PRIO));
    ssp_peer ssp_peer_i (.sclk(sclk_w), .mosi(peer_in), .miso(miso), .pol(pol), .load(load),
        .load_val(load_val), .sr(peer_sr));
    // 200 MHz clock
    initial begin
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end
    // Hang guard
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test;
        end
    end
    // Value after n shifts of a with b entering from below
    function automatic logic [7:0] sh(input logic [7:0] a, b, input int n);
        return (a << n) | (b >> (8 - n));
    endfunction : sh
    task automatic chk(input logic [31:0] g, x);
        comparisons++;
        if (g !== x) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    // One APB transfer, held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, d, output logic [31:0] r, output logic e);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        // Ready ends this wait; only the hang guard ends it if ready never comes
        do begin
            @(posedge CLK_SYS);
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h0, r, e);
        chk(r, x);
    endtask : rd
    // Configure under soft reset, preload the peer, start a transfer
    task automatic xfer(input logic [7:0] cfg, ctl, tx, pd);
        pol <= cfg[6];
        load_val <= pd;
        wr(ADDR_CONFIG, cfg | 8'h80);
        wr(ADDR_OPCTL, ctl);
        wr(ADDR_CONFIG, cfg);
        @(posedge CLK_SYS) load <= 1'b1;
        @(posedge CLK_SYS) load <= 1'b0;
        wr(ADDR_SHIFT, tx);
    endtask : xfer
    // Poll the control register until flag bit b is set
    task automatic wait_done(input int b);
        logic [31:0] r;
        logic        e;
        do begin
            apb(1'b0, ADDR_OPCTL, 8'h0, r, e);
        end while (r[b] !== 1'b1);
    endtask : wait_done
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(ADDR_CONFIG, {24'h0, CONFIG_RST});
        rd(ADDR_OPCTL, {24'h0, OPCTL_RST});
        rd(ADDR_PRIO, {24'h0, PRIO_RST});
        apb(1'b0, 8'h14, 8'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wr(ADDR_PRIO, 8'h40);
        rd(ADDR_PRIO, 32'h40);
        chk({31'h0, IRQ_PRIO}, 32'h1);
    endtask : t_regs
    task automatic t_full8;
        xfer(8'h07, 8'h07, 8'hA5, 8'h3C);
        wait_done(CTL_DONE_BIT);
        repeat (4) @(posedge CLK_SYS);
        chk({31'h0, IRQ}, 32'h1);
        rd(ADDR_SHIFT, 32'h3C);
        chk({24'h0, peer_sr}, 32'hA5);
        rd(ADDR_RXBUF, 32'h3C);
        rd(ADDR_OPCTL, 32'h07);
        chk({31'h0, IRQ}, 32'h0);
    endtask : t_full8
    task automatic t_short;
        xfer(8'h4A, 8'h07, 8'hA0, 8'hC5);
        wait_done(CTL_DONE_BIT);
        wr(ADDR_SHIFT, 8'hE0);
        // Completion flag still set, so wait on the overrun flag instead
        wait_done(CTL_OVR_BIT);
        rd(ADDR_OPCTL, 32'hC7);
        chk({24'h0, peer_sr}, {24'h0, sh(sh(8'hC5, 8'hA0, 3), 8'hE0, 3)});
        wr(ADDR_CONFIG, 8'hCA);
        wr(ADDR_SHIFT, 8'h55);
        repeat (20) @(posedge CLK_SYS);
        rd(ADDR_SHIFT, {24'h0, sh(8'hE0, sh(8'hC5, 8'hA0, 3), 3)});
        rd(ADDR_OPCTL, 32'h07);
        chk({31'h0, SCLK_O}, 32'h1);
        rd(ADDR_RXBUF, {24'h0, sh(8'hE0, sh(8'hC5, 8'hA0, 3), 3)});
    endtask : t_short
    task automatic t_transmit_permit_bit_rate;
        int n;
        xfer(8'h17, 8'h05, 8'h5A, 8'h96);
        for (n = 0; n < 40 && SCLK_O === 1'b0; n++) @(negedge CLK_SYS);
        for (n = 0; n < 40 && SCLK_O === 1'b1; n++) @(negedge CLK_SYS);
        chk(32'(n), 32'h4);
        chk({31'h0, MOSI_OE_N}, 32'h1);
        wait_done(CTL_DONE_BIT);
        rd(ADDR_RXBUF, 32'h96);
        chk({24'h0, peer_sr}, 32'hFF);
    endtask : t_transmit_permit_bit_rate
    // Port as slave, bench clocks it at system/8 with the slowest rate code set
    task automatic t_slave;
        slv <= 1'b1;
        xfer(8'h7F, 8'h03, 8'h69, 8'hB4);
        chk({31'h0, MISO_OE_N}, 32'h0);
        chk({31'h0, SCLK_OE_N}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(posedge CLK_SYS);
            ext_act <= 1'b1;
            repeat (4) @(posedge CLK_SYS);
            ext_act <= 1'b0;
        end
        wait_done(CTL_DONE_BIT);
        chk({31'h0, IRQ}, 32'h1);
        rd(ADDR_RXBUF, 32'hB4);
        chk({24'h0, peer_sr}, 32'h69);
    endtask : t_slave
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (4) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        t_regs;
        t_full8;
        t_short;
        t_transmit_permit_bit_rate;
        t_slave;
        finish_test;
    end
endmodule : ssp_port_tb
